// ==== rtl/ccg_top.sv ====
// module: cpu clock source select, divider and oscillator control
`timescale 1ns/1ps
module ccg_top #(
    parameter int CNT_W = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire ccg_pkg::ccg_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic stop_mode,
    input wire logic option_hs_rc,
    input wire logic option_int_stoppable,
    input wire logic hs_osc_in,
    input wire logic int_osc_in,
    input wire logic sub_osc_in,
    output logic hs_osc_run,
    output logic hs_osc_is_rc,
    output logic int_osc_run,
    output logic sub_osc_run,
    output logic feedback_res_on,
    output logic cpu_clk,
    output logic cpu_tick,
    output logic instr_tick
);

    //------------------------------------------------------------
    // parameter check
    //------------------------------------------------------------
    if (CNT_W < 4) begin : g_bad_cnt_w
        $error("counter too narrow for divide by 16");
    end

    //------------------------------------------------------------
    // register storage
    //------------------------------------------------------------
    logic [7:0] proc_clk_reg;
    logic int_halt_reg;
    logic main_sel_reg;
    logic hs_halt_reg;
    ccg_pkg::ccg_sel_t eff_reg;
    logic [7:0] rdata_reg;
    function automatic logic [7:0] ccg_merge(
        input logic [7:0] old,
        input ccg_pkg::ccg_bus_req_t r
    );
        logic [7:0] v;
        v = old;
        if (r.bit_wr) begin
            v[r.bit_idx] = r.bit_val;
        end else begin
            v = r.wdata;
        end
        return v;
    endfunction
    logic wr_any;
    logic [7:0] wr_proc;
    logic [7:0] wr_int;
    logic [7:0] wr_mode;
    logic [7:0] wr_hs;
    assign wr_any = bus_req.wr | bus_req.bit_wr;
    assign wr_proc = ccg_merge(proc_clk_reg, bus_req);
    assign wr_int = ccg_merge({7'h00, int_halt_reg}, bus_req);
    assign wr_mode = ccg_merge({6'h00, eff_reg.hs, main_sel_reg},
                               bus_req);
    assign wr_hs = ccg_merge({hs_halt_reg, 7'h00}, bus_req);

    //------------------------------------------------------------
    // processor clock control
    //------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            proc_clk_reg <= ccg_pkg::CCG_REG_RESET;
        end else if (wr_any &&
                     bus_req.addr == ccg_pkg::CCG_ADDR_PROC_CLK) begin
            proc_clk_reg <= wr_proc;
        end
    end

    //------------------------------------------------------------
    // internal oscillator mode
    //------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_halt_reg <= 1'b0;
        end else if (wr_any &&
                     bus_req.addr == ccg_pkg::CCG_ADDR_INT_OSC) begin
            int_halt_reg <= wr_int[ccg_pkg::CCG_BIT_INT_HALT];
        end
    end

    //------------------------------------------------------------
    // clock mode
    //------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            main_sel_reg <= 1'b0;
        end else if (wr_any &&
                     bus_req.addr == ccg_pkg::CCG_ADDR_CLK_MODE) begin
            main_sel_reg <= wr_mode[ccg_pkg::CCG_BIT_MAIN_SEL];
        end
    end

    //------------------------------------------------------------
    // high-speed oscillator control
    //------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hs_halt_reg <= 1'b0;
        end else if (wr_any &&
                     bus_req.addr == ccg_pkg::CCG_ADDR_HS_CTRL) begin
            hs_halt_reg <= wr_hs[ccg_pkg::CCG_BIT_HS_HALT];
        end
    end

    //------------------------------------------------------------
    // read port
    //------------------------------------------------------------
    logic [7:0] proc_rd;
    always_comb begin
        proc_rd = proc_clk_reg;
        proc_rd[ccg_pkg::CCG_BIT_SRC_STAT] = eff_reg.sub;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else if (bus_req.rd) begin
            if (bus_req.addr == ccg_pkg::CCG_ADDR_PROC_CLK) begin
                rdata_reg <= proc_rd;
            end else if (bus_req.addr == ccg_pkg::CCG_ADDR_INT_OSC) begin
                rdata_reg <= {7'h00, int_halt_reg};
            end else if (bus_req.addr == ccg_pkg::CCG_ADDR_CLK_MODE) begin
                rdata_reg <= {6'h00, eff_reg.hs, main_sel_reg};
            end else if (bus_req.addr == ccg_pkg::CCG_ADDR_HS_CTRL) begin
                rdata_reg <= {hs_halt_reg, 7'h00};
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end
    assign rdata = rdata_reg;

    //------------------------------------------------------------
    // oscillator enables
    //------------------------------------------------------------
    logic hs_osc_run_reg;
    logic hs_osc_is_rc_reg;
    logic int_osc_run_reg;
    logic sub_osc_run_reg;
    logic feedback_res_on_reg;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hs_osc_run_reg <= 1'b1;
        end else begin
            hs_osc_run_reg <= !(stop_mode || hs_halt_reg ||
                proc_clk_reg[ccg_pkg::CCG_BIT_HS_STOP]);
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hs_osc_is_rc_reg <= 1'b0;
        end else begin
            hs_osc_is_rc_reg <= option_hs_rc;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_osc_run_reg <= 1'b1;
        end else begin
            int_osc_run_reg <= !(int_halt_reg && option_int_stoppable &&
                eff_reg.hs && !eff_reg.sub);
        end
    end
    always_ff @(posedge clk) begin
        sub_osc_run_reg <= 1'b1;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            feedback_res_on_reg <= 1'b1;
        end else begin
            feedback_res_on_reg <=
                !proc_clk_reg[ccg_pkg::CCG_BIT_FB_OFF];
        end
    end
    assign hs_osc_run = hs_osc_run_reg;
    assign hs_osc_is_rc = hs_osc_is_rc_reg;
    assign int_osc_run = int_osc_run_reg;
    assign sub_osc_run = sub_osc_run_reg;
    assign feedback_res_on = feedback_res_on_reg;

    //------------------------------------------------------------
    // oscillator input synchronisers
    //------------------------------------------------------------
    logic [ccg_pkg::CCG_NUM_SRC-1:0] osc_in;
    logic [ccg_pkg::CCG_NUM_SRC-1:0] lvl;
    logic [ccg_pkg::CCG_NUM_SRC-1:0] rise;

    assign osc_in = {sub_osc_in, int_osc_in, hs_osc_in};

    genvar gi;
    generate
        for (gi = 0; gi < ccg_pkg::CCG_NUM_SRC; gi++) begin : g_sync
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    lvl_reg <= 1'b0;
                end else begin
                    s1_reg <= osc_in[gi];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        lvl_reg <= s3_reg;
                    end
                end
            end
            assign lvl[gi] = lvl_reg;
            assign rise[gi] = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
        end
    endgenerate

    //------------------------------------------------------------
    // requested selection and legality
    //------------------------------------------------------------
    ccg_pkg::ccg_sel_t req_sel;
    logic req_ok;

    always_comb begin
        req_sel.sub = proc_clk_reg[ccg_pkg::CCG_BIT_SUB_SEL];
        req_sel.hs = main_sel_reg;
        req_sel.div = proc_clk_reg[ccg_pkg::CCG_BIT_DIV_MSB:0];
        req_ok = (req_sel.div <= ccg_pkg::CCG_DIV_MAX);
        if (!req_sel.sub && !req_sel.hs &&
            req_sel.div > ccg_pkg::CCG_DIV_INT_MAX) begin
            req_ok = 1'b0;
        end
    end

    //------------------------------------------------------------
    // source mux and divider
    //------------------------------------------------------------
    logic sel_rise;
    logic sel_lvl;
    logic [2:0] shift;
    logic [CNT_W-1:0] ratio;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic last;

    always_comb begin
        if (eff_reg.sub) begin
            sel_rise = rise[ccg_pkg::CCG_SRC_SUB];
            sel_lvl = lvl[ccg_pkg::CCG_SRC_SUB];
            shift = ccg_pkg::CCG_DIV_SUB;
        end else if (eff_reg.hs) begin
            sel_rise = rise[ccg_pkg::CCG_SRC_HS];
            sel_lvl = lvl[ccg_pkg::CCG_SRC_HS];
            shift = eff_reg.div;
        end else begin
            sel_rise = rise[ccg_pkg::CCG_SRC_INT];
            sel_lvl = lvl[ccg_pkg::CCG_SRC_INT];
            shift = eff_reg.div;
        end
        ratio = CNT_W'((CNT_W+1)'(1) << shift) - CNT_W'(1);
        last = (cnt_reg == ratio);
        cnt_next = last ? '0 : cnt_reg + CNT_W'(1);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else if (sel_rise) begin
            cnt_reg <= cnt_next;
        end
    end

    //------------------------------------------------------------
    // glitch-free switch at period end
    //------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eff_reg <= '0;
        end else if (sel_rise && last && req_ok) begin
            eff_reg <= req_sel;
        end
    end

    //------------------------------------------------------------
    // cpu clock, tick and instruction slot
    //------------------------------------------------------------
    logic cpu_clk_reg;
    logic cpu_tick_reg;
    logic instr_tick_reg;
    logic phase_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpu_clk_reg <= 1'b0;
        end else if (sel_rise) begin
            cpu_clk_reg <= ({1'b0, cnt_next} <
                            (({1'b0, ratio} + (CNT_W+1)'(2)) >> 1));
        end else if (ratio == '0 && !sel_lvl) begin
            cpu_clk_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpu_tick_reg <= 1'b0;
        end else begin
            cpu_tick_reg <= sel_rise && last;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_reg <= 1'b0;
            instr_tick_reg <= 1'b0;
        end else begin
            instr_tick_reg <= sel_rise && last && phase_reg;
            if (sel_rise && last) begin
                phase_reg <= !phase_reg;
            end
        end
    end

    assign cpu_clk = cpu_clk_reg;
    assign cpu_tick = cpu_tick_reg;
    assign instr_tick = instr_tick_reg;

endmodule

// ==== rtl/ccg_pkg.sv ====
// package: constants and types of the clock generator
//------------------------------------------------------------
// Functional notes
// - high-speed oscillator type comes from option byte
// - stop mode or either stop bit halts high-speed
// - internal halt needs option permit and high-speed cpu
// - subsystem oscillator always runs, never stoppable
// - reset clears processor clock control to zero
// - processor clock control takes bit or byte writes
// - bit 7: 1 stops high-speed oscillator
// - bit 6: 1 disconnects subsystem feedback resistor
// - bit 5 read-only: 1 means cpu on subsystem
// - source bit and divider code select cpu clock
// - main clock select; internal allows only /1, /2
// - fastest instruction takes two cpu clocks
// - clock mode bit 0 chooses internal or high-speed
// - clock mode bit 1 reports actual main clock
// - control bit 7: 1 stops high-speed oscillator
// - internal mode bit 0: 1 stops internal osc
package ccg_pkg;

    //------------------------------------------------------------
    // register addresses
    //------------------------------------------------------------
    localparam logic [15:0] CCG_ADDR_PROC_CLK = 16'hFFFB;
    localparam logic [15:0] CCG_ADDR_INT_OSC = 16'hFFA0;
    localparam logic [15:0] CCG_ADDR_CLK_MODE = 16'hFFA1;
    localparam logic [15:0] CCG_ADDR_HS_CTRL = 16'hFFA2;
    localparam logic [7:0] CCG_REG_RESET = 8'h00;

    //------------------------------------------------------------
    // field positions
    //------------------------------------------------------------
    localparam int CCG_BIT_HS_STOP = 7;
    localparam int CCG_BIT_FB_OFF = 6;
    localparam int CCG_BIT_SRC_STAT = 5;
    localparam int CCG_BIT_SUB_SEL = 4;
    localparam int CCG_BIT_DIV_MSB = 2;
    localparam int CCG_BIT_MAIN_SEL = 0;
    localparam int CCG_BIT_MAIN_STAT = 1;
    localparam int CCG_BIT_HS_HALT = 7;
    localparam int CCG_BIT_INT_HALT = 0;

    //------------------------------------------------------------
    // divider codes and sources
    //------------------------------------------------------------
    localparam logic [2:0] CCG_DIV_MAX = 3'h4;
    localparam logic [2:0] CCG_DIV_INT_MAX = 3'h1;
    localparam logic [2:0] CCG_DIV_SUB = 3'h1;
    localparam int CCG_NUM_SRC = 3;
    localparam int CCG_SRC_HS = 0;
    localparam int CCG_SRC_INT = 1;
    localparam int CCG_SRC_SUB = 2;

    //------------------------------------------------------------
    // carriers
    //------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic bit_wr;
        logic rd;
        logic [2:0] bit_idx;
        logic bit_val;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ccg_bus_req_t;

    typedef struct packed {
        logic sub;
        logic hs;
        logic [2:0] div;
    } ccg_sel_t;

endpackage

// ==== sim/ccg_osc_model.sv ====
// partner: three oscillator sources that stand still when stopped
`timescale 1ns/1ps
module ccg_osc_model #(
    parameter int HS_HALF = 30,
    parameter int INT_HALF = 50,
    parameter int SUB_HALF = 70
) (
    input wire logic hs_run,
    input wire logic int_run,
    input wire logic sub_run,
    output logic hs_osc,
    output logic int_osc,
    output logic sub_osc
);
    initial begin
        hs_osc = 1'b0;
        #3;
        forever #HS_HALF hs_osc = hs_run & ~hs_osc;
    end
    initial begin
        int_osc = 1'b0;
        #7;
        forever #INT_HALF int_osc = int_run & ~int_osc;
    end
    initial begin
        sub_osc = 1'b0;
        #1;
        forever #SUB_HALF sub_osc = sub_run & ~sub_osc;
    end
endmodule

// ==== sim/ccg_top_sva.sv ====
// checker: port properties of the clock generator
`timescale 1ns/1ps
module ccg_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire ccg_pkg::ccg_bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire logic stop_mode,
    input wire logic option_hs_rc,
    input wire logic option_int_stoppable,
    input wire logic hs_osc_run,
    input wire logic hs_osc_is_rc,
    input wire logic int_osc_run,
    input wire logic sub_osc_run,
    input wire logic feedback_res_on,
    input wire logic cpu_clk,
    input wire logic cpu_tick,
    input wire logic instr_tick
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic hs_stop_reg, fb_off_reg, hs_halt_reg;
    logic [1:0] tick_cnt_reg;
    //------------------------------------------------------------
    // shadow of written control bits
    //------------------------------------------------------------
    function automatic logic upd(input logic old, input logic [15:0] a,
                                 input logic [2:0] k);
        if (bus_req.addr != a) return old;
        if (bus_req.bit_wr)
            return (bus_req.bit_idx == k) ? bus_req.bit_val : old;
        if (bus_req.wr) return bus_req.wdata[k];
        return old;
    endfunction
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hs_stop_reg <= 1'b0;
            fb_off_reg <= 1'b0;
            hs_halt_reg <= 1'b0;
        end else begin
            hs_stop_reg <= upd(hs_stop_reg, ccg_pkg::CCG_ADDR_PROC_CLK, 3'h7);
            fb_off_reg <= upd(fb_off_reg, ccg_pkg::CCG_ADDR_PROC_CLK, 3'h6);
            hs_halt_reg <= upd(hs_halt_reg, ccg_pkg::CCG_ADDR_HS_CTRL, 3'h7);
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst || instr_tick) tick_cnt_reg <= 2'h0;
        else if (cpu_tick) tick_cnt_reg <= tick_cnt_reg + 2'h1;
    end
    //------------------------------------------------------------
    // properties
    //------------------------------------------------------------
    sequence s_pulse;
        cpu_tick ##1 !cpu_tick;
    endsequence
    property p_reset_out;
        $past(sys_rst) |-> rdata == 8'h00 && hs_osc_run && int_osc_run
            && feedback_res_on && !cpu_tick;
    endproperty
    property p_hs_run;
        !$past(sys_rst) |->
            hs_osc_run == !$past(stop_mode || hs_stop_reg || hs_halt_reg);
    endproperty
    property p_hs_bit7;
        hs_stop_reg |=> !hs_osc_run;
    endproperty
    property p_hs_halt;
        hs_halt_reg |=> !hs_osc_run;
    endproperty
    property p_fb;
        !$past(sys_rst) |-> feedback_res_on == !$past(fb_off_reg);
    endproperty
    property p_sub;
        sub_osc_run;
    endproperty
    property p_rc;
        !$past(sys_rst) |-> hs_osc_is_rc == $past(option_hs_rc);
    endproperty
    property p_int_keep;
        !option_int_stoppable |=> int_osc_run;
    endproperty
    property p_tick;
        cpu_tick |-> s_pulse;
    endproperty
    property p_instr_src;
        instr_tick |-> cpu_tick;
    endproperty
    property p_instr_pair;
        cpu_tick && tick_cnt_reg != 2'h0 |-> instr_tick;
    endproperty
    property p_instr_gap;
        instr_tick |-> tick_cnt_reg == 2'h1;
    endproperty
    property p_cpu_clk;
        $rose(cpu_clk) |-> cpu_tick || $past(cpu_tick);
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs wrong after reset");
    a_hs_run: assert property (p_hs_run)
        else $error("high-speed enable wrong");
    a_hs_bit7: assert property (p_hs_bit7)
        else $error("stop bit did not halt high-speed");
    a_hs_halt: assert property (p_hs_halt)
        else $error("halt bit did not halt high-speed");
    a_fb: assert property (p_fb)
        else $error("feedback resistor state wrong");
    a_sub: assert property (p_sub)
        else $error("subsystem oscillator stopped");
    a_rc: assert property (p_rc)
        else $error("oscillator type not from option");
    a_int_keep: assert property (p_int_keep)
        else $error("internal oscillator stopped without permit");
    a_tick: assert property (p_tick)
        else $error("cpu tick longer than one cycle");
    a_instr_src: assert property (p_instr_src)
        else $error("instruction tick without cpu tick");
    a_instr_pair: assert property (p_instr_pair)
        else $error("instruction tick missing on second cpu tick");
    a_instr_gap: assert property (p_instr_gap)
        else $error("instruction tick on first cpu tick");
    a_cpu_clk: assert property (p_cpu_clk)
        else $error("cpu clock rose away from period start");
endmodule

// ==== sim/test_cpu_clock_generator_select.sv ====
// testbench: clock generator registers, dividers and oscillator enables
`timescale 1ns/1ps
module test_cpu_clock_generator_select;
    typedef struct {
        logic [15:0] a;
        logic [7:0] d, r;
        logic hs, fb;
    } ccg_row_t;
    logic clk, sys_rst, stop_mode, option_hs_rc, option_int_stoppable;
    logic hs_osc_in, int_osc_in, sub_osc_in, hs_osc_run, hs_osc_is_rc;
    logic int_osc_run, sub_osc_run, feedback_res_on, cpu_clk, cpu_tick;
    logic instr_tick;
    logic [7:0] rdata;
    ccg_pkg::ccg_bus_req_t bus_req;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int clk_rises = 0;
    always @(posedge cpu_clk) clk_rises++;
    logic [15:0] regs [4] = '{16'hFFFB, 16'hFFA0, 16'hFFA1, 16'hFFA2};
    ccg_row_t rows [8] = '{
        '{16'hFFFB, 8'h40, 8'h40, 1'b1, 1'b0},
        '{16'hFFFB, 8'h20, 8'h00, 1'b1, 1'b1},
        '{16'hFFA2, 8'hFF, 8'h80, 1'b0, 1'b1},
        '{16'hFFA2, 8'h00, 8'h00, 1'b1, 1'b1},
        '{16'hFFA0, 8'hFF, 8'h01, 1'b1, 1'b1},
        '{16'hFFA0, 8'h00, 8'h00, 1'b1, 1'b1},
        '{16'hFFA1, 8'hFE, 8'h00, 1'b1, 1'b1},
        '{16'hFFF0, 8'hFF, 8'h00, 1'b1, 1'b1}};
    ccg_top #(.CNT_W(4)) i_ccg_top (.clk(clk), .sys_rst(sys_rst),
        .bus_req(bus_req), .rdata(rdata), .stop_mode(stop_mode),
        .option_hs_rc(option_hs_rc),
        .option_int_stoppable(option_int_stoppable), .hs_osc_in(hs_osc_in),
        .int_osc_in(int_osc_in), .sub_osc_in(sub_osc_in),
        .hs_osc_run(hs_osc_run), .hs_osc_is_rc(hs_osc_is_rc),
        .int_osc_run(int_osc_run), .sub_osc_run(sub_osc_run),
        .feedback_res_on(feedback_res_on), .cpu_clk(cpu_clk),
        .cpu_tick(cpu_tick), .instr_tick(instr_tick));
    ccg_osc_model i_ccg_osc_model (.hs_run(hs_osc_run),
        .int_run(int_osc_run), .sub_run(sub_osc_run), .hs_osc(hs_osc_in),
        .int_osc(int_osc_in), .sub_osc(sub_osc_in));
    //------------------------------------------------------------
    // tasks
    //------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        bus_req = '{wr: 1'b1, addr: a, wdata: d, default: '0};
        @(negedge clk);
        bus_req.wr = 1'b0;
    endtask
    task automatic bw(input logic [15:0] a, input logic [2:0] k,
                      input logic v);
        @(negedge clk);
        bus_req = '{bit_wr: 1'b1, addr: a, bit_idx: k, bit_val: v,
                    default: '0};
        @(negedge clk);
        bus_req.bit_wr = 1'b0;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        bus_req = '{rd: 1'b1, addr: a, default: '0};
        @(negedge clk);
        bus_req.rd = 1'b0;
        @(negedge clk);
        chk(32'(rdata), 32'(e));
    endtask
    task automatic tick(inout int n);
        do begin
            @(negedge clk);
            n++;
        end while (!cpu_tick && n < 1000);
    endtask
    task automatic per(input int e);
        int n;
        int r;
        n = 0;
        repeat (3) tick(n);
        n = 0;
        r = clk_rises;
        tick(n);
        chk(32'(n), 32'(e));
        chk(32'(clk_rises - r), 32'h1);
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    //------------------------------------------------------------
    // clock, timeout, sequence
    //------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        bus_req = '0;
        sys_rst = 1'b1;
        stop_mode = 1'b0;
        option_hs_rc = 1'b0;
        option_int_stoppable = 1'b0;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        foreach (regs[i]) rchk(regs[i], 8'h00);
        chk(32'({hs_osc_run, int_osc_run, feedback_res_on}), 32'h7);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].r);
            chk(32'(hs_osc_run), 32'(rows[i].hs));
            chk(32'(feedback_res_on), 32'(rows[i].fb));
        end
        bw(16'hFFFB, 3'h6, 1'b1);
        rchk(16'hFFFB, 8'h40);
        bw(16'hFFFB, 3'h6, 1'b0);
        rchk(16'hFFFB, 8'h00);
        $display("register test done");
        per(10);
        wr(16'hFFFB, 8'h01);
        per(20);
        wr(16'hFFFB, 8'h02);
        per(20);
        wr(16'hFFFB, 8'h00);
        $display("internal clock test done");
        option_hs_rc = 1'b1;
        wr(16'hFFA1, 8'h01);
        per(6);
        rchk(16'hFFA1, 8'h03);
        chk(32'(hs_osc_is_rc), 32'h1);
        wr(16'hFFFB, 8'h04);
        per(96);
        option_int_stoppable = 1'b1;
        wr(16'hFFA0, 8'h01);
        repeat (2) @(negedge clk);
        chk(32'(int_osc_run), 32'h0);
        wr(16'hFFA0, 8'h00);
        stop_mode = 1'b1;
        repeat (2) @(negedge clk);
        chk(32'(hs_osc_run), 32'h0);
        stop_mode = 1'b0;
        wr(16'hFFFB, 8'h00);
        per(6);
        $display("high-speed clock test done");
        wr(16'hFFFB, 8'h10);
        per(28);
        rchk(16'hFFFB, 8'h30);
        wr(16'hFFFB, 8'h90);
        repeat (2) @(negedge clk);
        chk(32'(hs_osc_run), 32'h0);
        wr(16'hFFFB, 8'h95);
        per(28);
        wr(16'hFFFB, 8'h10);
        wr(16'hFFFB, 8'h00);
        per(6);
        rchk(16'hFFFB, 8'h00);
        $display("subsystem clock test done");
        final_report();
    end
endmodule

bind ccg_top ccg_checker i_ccg_checker (.clk(clk), .sys_rst(sys_rst),
    .bus_req(bus_req), .rdata(rdata), .stop_mode(stop_mode),
    .option_hs_rc(option_hs_rc),
    .option_int_stoppable(option_int_stoppable), .hs_osc_run(hs_osc_run),
    .hs_osc_is_rc(hs_osc_is_rc), .int_osc_run(int_osc_run),
    .sub_osc_run(sub_osc_run), .feedback_res_on(feedback_res_on),
    .cpu_clk(cpu_clk), .cpu_tick(cpu_tick), .instr_tick(instr_tick));
